// ==== ctb_tx_ctrl.sv ====
// Transmit buffer control: empty flags, abort handling, buffer select and window access
// Function
// RQ1: The interrupt enable register at index 0x07 is held in reset in init mode and written only outside it; the code needs init request and ack both low.
// RQ2: Each buffer's enable bit lets its empty flag raise the transmit interrupt, a zero bit suppresses it.
// RQ3: The abort request register at index 0x08 is held in reset in init mode and written only outside it; the code needs init request and ack both low.
// RQ4: Software requests an abort only for a buffer that is scheduled, with its empty flag at zero.
// RQ5: An abort is granted only if the message has not started or its attempt failed by lost arbitration or error.
// RQ6: An aborted buffer gets its empty flag and abort acknowledge set and raises the interrupt when enabled.
// RQ7: Software cannot clear an abort request; it clears itself when the buffer's empty flag becomes set.
// RQ8: The abort acknowledge register at index 0x09 is held in reset in init mode and ignores writes.
// RQ9: An abort acknowledge flag shows whether the message was aborted and clears when the empty flag clears.
// RQ10: The buffer select register at index 0x0A is held in reset in init mode and written only outside it; the code needs init request and ack both low.
// RQ11: Only the lowest set select bit picks the windowed buffer, and a read shows that bit alone.
// RQ12: Window accesses to the selected buffer are blocked while that buffer is scheduled.
// RQ13: With no select bit set, no window access is permitted.
// RQ14: Software finds a free buffer by copying the transmit flag register into the select register.
// RQ15: An empty flag reads one for an empty buffer and zero when scheduled, and is set after a successful send.
// RQ16: Outside init mode writing one to an empty flag clears it and writing zero leaves it; the code accepts it only with init request and ack both low.
// RQ17: The transmit interrupt output is high while any buffer has both its empty flag and enable set.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module ctb_tx_ctrl
  import ctb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Protocol engine
  input wire logic init_ack_i,
  input wire logic [2:0] tx_busy_i,
  input wire logic [2:0] tx_success_i,
  input wire logic [2:0] tx_fail_i,
  input wire logic [1:0] eng_rd_buf_i,
  input wire logic [3:0] eng_rd_addr_i,
  output logic [7:0] eng_rd_data_o,
  output logic [2:0] tx_pending_o,
  output logic [2:0] abort_grant_o,
  output logic init_request_o,
  // Interrupts
  output logic tx_irq_o,
  output logic irq_o
);

  logic ack_ff;
  logic [31:0] rdat_ff;
  logic init_request_ff;
  logic [2:0] txe_ff;
  logic [2:0] irq_en_ff;
  logic [2:0] abort_req_ff;
  logic [2:0] abort_ack_ff;
  logic [2:0] buf_sel_ff;
  logic tx_irq_ff;
  logic [2:0] abort_grant_ff;
  logic [2:0] tx_pending_ff;
  logic [7:0] eng_data_ff;

  logic init_mode;
  logic hold_rst;
  logic wr_ok;
  logic req;
  logic wr_commit;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic byte_wr;
  logic win_hit;
  logic [2:0] sel_low;
  logic [1:0] sel_idx;
  logic win_open;
  logic win_wr;
  logic blocked_evt;
  logic [2:0] grant;
  logic [2:0] nxt_txe;
  logic [2:0] nxt_abort_req;
  logic [2:0] nxt_abort_ack;
  logic [7:0] ram_rdata;
  logic [7:0] eng_data;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic irq_unit_o;
  logic [31:0] rd_data;
  logic wr_tx_flag;
  logic wr_irq_en;
  logic wr_abort_req;
  logic wr_buf_sel;
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_mask;

  // Init mode needs both request and acknowledge; writes to the locked registers need both low
  assign init_mode = init_request_ff && init_ack_i;
  assign hold_rst = rst_i || init_mode;
  assign wr_ok = !init_request_ff && !init_ack_i;

  // Bus cycle: ack follows one cycle after the request and the write lands on the ack edge
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_commit = req && wb_we_i && ack_ff;
  assign idx = wb_adr_i[7:2];
  assign wbyte = wb_dat_i[7:0];
  assign byte_wr = wr_commit && wb_sel_i[0];

  // Window selection
  assign sel_low = ctb_lowest_one(buf_sel_ff); // RQ11
  assign sel_idx = ctb_onehot_idx(sel_low);
  assign win_hit = (idx >= IDX_WIN_BASE) && (idx <= IDX_WIN_LAST);
  assign win_open = (|sel_low) && |(sel_low & txe_ff); // RQ12 RQ13
  assign win_wr = byte_wr && win_hit && win_open;
  // Report a refused window access once, on its ack edge
  assign blocked_evt = req && ack_ff && win_hit && !win_open;

  // One write strobe per register; the init-mode lock is folded into the
  // strobes of the locked registers so the flag logic below stays simple
  always_comb begin
    wr_tx_flag = 1'b0;
    wr_irq_en = 1'b0;
    wr_abort_req = 1'b0;
    wr_buf_sel = 1'b0;
    wr_ctrl = 1'b0;
    wr_irq_clr = 1'b0;
    wr_irq_mask = 1'b0;
    if (byte_wr && idx == IDX_TX_FLAG) begin
      wr_tx_flag = wr_ok; // RQ16
    end else if (byte_wr && idx == IDX_TX_IRQ_EN) begin
      wr_irq_en = wr_ok; // RQ1
    end else if (byte_wr && idx == IDX_ABORT_REQ) begin
      wr_abort_req = wr_ok; // RQ3
    end else if (byte_wr && idx == IDX_BUF_SEL) begin
      wr_buf_sel = wr_ok; // RQ10
    end else if (byte_wr && idx == IDX_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (byte_wr && idx == IDX_IRQ_STATUS) begin
      wr_irq_clr = 1'b1;
    end else if (byte_wr && idx == IDX_IRQ_MASK) begin
      wr_irq_mask = 1'b1;
    end
  end

  // Abort is only granted before the frame starts or after a failed attempt;
  // a success in the same cycle wins so the buffer reports a sent message
  assign grant = abort_req_ff & ~txe_ff & (~tx_busy_i | tx_fail_i) & ~tx_success_i; // RQ5

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req && !ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_request_ff <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      init_request_ff <= wbyte[CTRL_INIT_REQ_BIT];
    end
  end

  // Empty flags: hardware sets win over a software clear in the same cycle
  always_comb begin
    nxt_txe = txe_ff;
    if (wr_tx_flag) begin
      nxt_txe = nxt_txe & ~wbyte[2:0]; // RQ16
    end
    nxt_txe = nxt_txe | tx_success_i | grant; // RQ15 RQ6
  end

  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      txe_ff <= TXE_RST;
    end else if (ce_i) begin
      txe_ff <= nxt_txe;
    end
  end

  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      irq_en_ff <= IRQ_EN_RST; // RQ1
    end else if (ce_i && wr_irq_en) begin
      irq_en_ff <= wbyte[2:0]; // RQ1
    end
  end

  // Abort requests: writes only set bits; the empty flag going high clears them
  always_comb begin
    nxt_abort_req = abort_req_ff;
    if (wr_abort_req) begin
      nxt_abort_req = nxt_abort_req | (wbyte[2:0] & ~txe_ff); // RQ3 RQ4
    end
    nxt_abort_req = nxt_abort_req & ~(nxt_txe & ~txe_ff); // RQ7
    nxt_abort_req = nxt_abort_req & ~txe_ff; // RQ7
  end

  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      abort_req_ff <= ABORT_REQ_RST; // RQ3
    end else if (ce_i) begin
      abort_req_ff <= nxt_abort_req;
    end
  end

  // Acknowledge flags ignore bus writes
  always_comb begin
    nxt_abort_ack = abort_ack_ff & nxt_txe; // RQ9
    nxt_abort_ack = nxt_abort_ack | grant; // RQ6
  end

  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      abort_ack_ff <= ABORT_ACK_RST; // RQ8
    end else if (ce_i) begin
      abort_ack_ff <= nxt_abort_ack; // RQ8
    end
  end

  // All three bits are stored; only the lowest one is visible and effective
  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      buf_sel_ff <= BUF_SEL_RST; // RQ10
    end else if (ce_i && wr_buf_sel) begin
      buf_sel_ff <= wbyte[2:0]; // RQ10
    end
  end

  // Outputs to the protocol engine
  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      abort_grant_ff <= 3'h0;
    end else if (ce_i) begin
      abort_grant_ff <= grant;
    end
  end

  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      tx_pending_ff <= ~TXE_RST;
    end else if (ce_i) begin
      tx_pending_ff <= ~nxt_txe;
    end
  end

  // Transmit interrupt is a level, registered from next-state flags
  always_ff @(posedge clk_i) begin
    if (hold_rst) begin
      tx_irq_ff <= 1'b0;
    end else if (ce_i) begin
      tx_irq_ff <= |(nxt_txe & irq_en_ff); // RQ2 RQ17 RQ6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_data_ff <= 8'h00;
    end else if (ce_i) begin
      eng_data_ff <= eng_data;
    end
  end

  ctb_msg_ram u_ram (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .wr_en_i(win_wr),
    .buf_i(sel_idx),
    .addr_i(idx[3:0]),
    .wdata_i(wbyte),
    .rdata_o(ram_rdata),
    .eng_buf_i(eng_rd_buf_i),
    .eng_addr_i(eng_rd_addr_i),
    .eng_data_o(eng_data)
  );

  // Events: successful send per buffer, abort per buffer, refused window access
  assign irq_evt = {blocked_evt, grant, tx_success_i & ~txe_ff};

  ctb_irq_unit u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .evt_i(irq_evt),
    .clr_wr_i(wr_irq_clr),
    .mask_wr_i(wr_irq_mask),
    .wdata_i(wbyte[IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_unit_o)
  );

  // Read decode; unmapped indices and blocked window reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (idx == IDX_TX_FLAG) begin
      rd_data[2:0] = txe_ff;
    end else if (idx == IDX_TX_IRQ_EN) begin
      rd_data[2:0] = irq_en_ff;
    end else if (idx == IDX_ABORT_REQ) begin
      rd_data[2:0] = abort_req_ff;
    end else if (idx == IDX_ABORT_ACK) begin
      rd_data[2:0] = abort_ack_ff;
    end else if (idx == IDX_BUF_SEL) begin
      rd_data[2:0] = sel_low; // RQ11
    end else if (idx == IDX_CTRL) begin
      rd_data[CTRL_INIT_REQ_BIT] = init_request_ff;
      rd_data[CTRL_INIT_ACK_BIT] = init_ack_i;
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_data[IRQ_W-1:0] = irq_status;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_data[IRQ_W-1:0] = irq_mask;
    end else if (win_hit && win_open) begin
      rd_data[7:0] = ram_rdata; // RQ12 RQ13
    end
  end

  // Read data is captured on the request edge and shown in the ack cycle only;
  // it drops with ack so a stale value never sits on the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      if (req && !ack_ff && !wb_we_i) begin
        rdat_ff <= rd_data;
      end else begin
        rdat_ff <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign init_request_o = init_request_ff;
  assign tx_pending_o = tx_pending_ff;
  assign abort_grant_o = abort_grant_ff;
  assign eng_rd_data_o = eng_data_ff;
  assign tx_irq_o = tx_irq_ff;
  assign irq_o = irq_unit_o;

endmodule

// ==== ctb_pkg.sv ====
// Constants, register map and helper functions for the CAN transmit buffer control block
package ctb_pkg;

  localparam int NUM_BUF = 3;
  localparam int BUF_BYTES = 16;
  localparam int IDX_W = 6;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_TX_FLAG = 6'h06;
  localparam logic [5:0] IDX_TX_IRQ_EN = 6'h07;
  localparam logic [5:0] IDX_ABORT_REQ = 6'h08;
  localparam logic [5:0] IDX_ABORT_ACK = 6'h09;
  localparam logic [5:0] IDX_BUF_SEL = 6'h0A;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;
  localparam logic [5:0] IDX_WIN_BASE = 6'h20;
  localparam logic [5:0] IDX_WIN_LAST = 6'h2F;

  // Control register fields
  localparam int CTRL_INIT_REQ_BIT = 0;
  localparam int CTRL_INIT_ACK_BIT = 1;

  // Event status fields
  localparam int IRQ_W = 7;
  localparam int IRQ_SENT_LSB = 0;
  localparam int IRQ_ABORT_LSB = 3;
  localparam int IRQ_BLOCKED_BIT = 6;

  // Reset values
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  localparam logic [2:0] ABORT_REQ_RST = 3'h0;
  localparam logic [2:0] ABORT_ACK_RST = 3'h0;
  localparam logic [2:0] BUF_SEL_RST = 3'h0;
  localparam logic [6:0] IRQ_MASK_RST = 7'h00;

  // Keep only the lowest set bit
  function automatic logic [2:0] ctb_lowest_one(input logic [2:0] v);
    logic [2:0] r;
    r = 3'h0;
    if (v[0]) begin
      r = 3'h1;
    end else if (v[1]) begin
      r = 3'h2;
    end else if (v[2]) begin
      r = 3'h4;
    end
    return r;
  endfunction

  // Index of a one-hot buffer select
  function automatic logic [1:0] ctb_onehot_idx(input logic [2:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[1]) begin
      r = 2'h1;
    end else if (v[2]) begin
      r = 2'h2;
    end
    return r;
  endfunction

endpackage

// ==== ctb_msg_ram.sv ====
// Message storage for the three transmit buffers
`timescale 1ns/1ps
module ctb_msg_ram
  import ctb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  input wire logic ce_i,
  // Bus write and read port
  input wire logic wr_en_i,
  input wire logic [1:0] buf_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Protocol engine read port
  input wire logic [1:0] eng_buf_i,
  input wire logic [3:0] eng_addr_i,
  output logic [7:0] eng_data_o
);

  logic [7:0] mem [NUM_BUF*BUF_BYTES];
  logic [5:0] wr_ptr;
  logic [5:0] eng_ptr;

  // Buffer n occupies bytes n*16 .. n*16+15
  assign wr_ptr = {buf_i, addr_i};
  assign eng_ptr = {eng_buf_i, eng_addr_i};

  always_ff @(posedge clk_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_ptr] <= wdata_i;
    end
  end

  // Contents are not reset, so reads are combinational and the caller registers them
  assign rdata_o = (wr_ptr < 6'(NUM_BUF * BUF_BYTES)) ? mem[wr_ptr] : 8'h00;
  assign eng_data_o = (eng_ptr < 6'(NUM_BUF * BUF_BYTES)) ? mem[eng_ptr] : 8'h00;

endmodule

// ==== ctb_irq_unit.sv ====
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
module ctb_irq_unit
  import ctb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Events and software access
  input wire logic [IRQ_W-1:0] evt_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [IRQ_W-1:0] wdata_i,
  // State
  output logic [IRQ_W-1:0] status_o,
  output logic [IRQ_W-1:0] mask_o,
  output logic irq_o
);

  logic [IRQ_W-1:0] status_ff;
  logic [IRQ_W-1:0] mask_ff;
  logic irq_ff;
  logic [IRQ_W-1:0] nxt_status;

  // A new event beats a write-one-to-clear in the same cycle
  always_comb begin
    nxt_status = status_ff;
    if (clr_wr_i) begin
      nxt_status = nxt_status & ~wdata_i;
    end
    nxt_status = nxt_status | evt_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= '0;
    end else if (ce_i) begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= IRQ_MASK_RST;
    end else if (ce_i && mask_wr_i) begin
      mask_ff <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign status_o = status_ff;
  assign mask_o = mask_ff;
  assign irq_o = irq_ff;

endmodule

// ==== ctb_tx_ctrl_assertions.sv ====
// Port-level checks for the transmit buffer control block
`timescale 1ns/1ps
module ctb_tx_ctrl_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Engine
  input wire logic init_ack_i,
  input wire logic [2:0] tx_busy_i,
  input wire logic [2:0] tx_success_i,
  input wire logic [2:0] tx_fail_i,
  input wire logic [2:0] tx_pending_o,
  input wire logic [2:0] abort_grant_o,
  input wire logic init_request_o,
  input wire logic tx_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_pulse: assert property (s_req |=> s_pulse)
    else $error("ack missing or longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_init_hold: assert property (
    init_request_o && init_ack_i |=> tx_pending_o == 3'h0 && !tx_irq_o)
    else $error("state not held in init mode");
  chk_success_set: assert property (
    ce_i && tx_success_i != 3'h0 |=> (tx_pending_o & $past(tx_success_i)) == 3'h0)
    else $error("flag not set after success");
  chk_grant_flag: assert property ((abort_grant_o & tx_pending_o) == 3'h0)
    else $error("grant while buffer scheduled");
  chk_grant_once: assert property (
    abort_grant_o != 3'h0 |=> (abort_grant_o & $past(abort_grant_o)) == 3'h0)
    else $error("grant repeated");
  chk_grant_cause: assert property (abort_grant_o != 3'h0 |->
    (abort_grant_o & ~$past(tx_pending_o & ~tx_success_i & (~tx_busy_i | tx_fail_i))) == 3'h0)
    else $error("grant without cause");
  chk_irq_none: assert property (tx_pending_o == 3'h7 |-> !tx_irq_o)
    else $error("tx irq with no empty buffer");
endmodule

bind ctb_tx_ctrl ctb_tx_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .init_ack_i(init_ack_i), .tx_busy_i(tx_busy_i), .tx_success_i(tx_success_i),
  .tx_fail_i(tx_fail_i), .tx_pending_o(tx_pending_o), .abort_grant_o(abort_grant_o),
  .init_request_o(init_request_o), .tx_irq_o(tx_irq_o));

// ==== tb_can_tx_buffer_abort_select.sv ====
// Self-checking bench for the transmit buffer control block
`timescale 1ns/1ps
module tb_can_tx_buffer_abort_select;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic init_ack_i, init_request_o, tx_irq_o, irq_o;
  logic [7:0] wb_adr_i, eng_rd_data_o, q, d;
  logic [3:0] wb_sel_i, eng_rd_addr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0] tx_busy_i, tx_success_i, tx_fail_i, tx_pending_o, abort_grant_o;
  logic [1:0] eng_rd_buf_i;
  int miscompares = 0;
  int total_checks = 0;
  integer seed = 32'h9DA302B6;

  ctb_tx_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .init_ack_i(init_ack_i),
    .tx_busy_i(tx_busy_i), .tx_success_i(tx_success_i), .tx_fail_i(tx_fail_i),
    .eng_rd_buf_i(eng_rd_buf_i), .eng_rd_addr_i(eng_rd_addr_i), .eng_rd_data_o(eng_rd_data_o),
    .tx_pending_o(tx_pending_o), .abort_grant_o(abort_grant_o),
    .init_request_o(init_request_o), .tx_irq_o(tx_irq_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Holds the request until ack is sampled; only the watchdog ends a hung wait
  task automatic wbx(input logic w, input logic [5:0] a, input logic [7:0] v);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'h0};
    wb_dat_i <= {24'h0, v};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    wbx(1'h1, a, v);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    wbx(1'h0, a, 8'h0);
    chk(q, e);
  endtask

  task automatic pulse(input logic [2:0] s, input logic [2:0] f);
    tx_success_i <= s;
    tx_fail_i <= f;
    @(posedge clk_i);
    tx_success_i <= 3'h0;
    tx_fail_i <= 3'h0;
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] low1(input logic [2:0] v);
    return {5'h0, v & (~v + 3'h1)};
  endfunction

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end

  initial begin
    {rst_i, ce_i, wb_sel_i} = 6'h3F;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, init_ack_i} = '0;
    {tx_busy_i, tx_success_i, tx_fail_i, eng_rd_buf_i, eng_rd_addr_i} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rc(6'h06, 8'h07);
    rc(6'h07, 8'h00);
    rc(6'h08, 8'h00);
    rc(6'h09, 8'h00);
    rc(6'h0A, 8'h00);
    rc(6'h05, 8'h00);
    wr(6'h20, 8'h5A);
    rc(6'h20, 8'h00);
    rc(6'h11, 8'h40);
    chk(irq_o, 1'h0);
    wr(6'h12, 8'h40);
    @(posedge clk_i);
    chk(irq_o, 1'h1);
    wr(6'h11, 8'h40);
    chk(irq_o, 1'h0);
    wr(6'h0A, 8'h06);
    rc(6'h0A, 8'h02);
    repeat (8) begin
      d = 8'($random(seed));
      wr(6'h0A, d);
      rc(6'h0A, low1(d[2:0]));
    end
    wr(6'h0A, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(6'h20 | i[5:0], d);
      rc(6'h20 | i[5:0], d);
    end
    eng_rd_addr_i <= 4'h3;
    repeat (2) @(posedge clk_i);
    chk(eng_rd_data_o, d);
    tx_busy_i <= 3'h7;
    wr(6'h06, 8'h01);
    chk(tx_pending_o, 3'h1);
    wr(6'h06, 8'h00);
    rc(6'h06, 8'h06);
    rc(6'h23, 8'h00);
    rc(6'h11, 8'h40);
    wr(6'h11, 8'h7F);
    rc(6'h06, 8'h06);
    wr(6'h0A, q);
    rc(6'h0A, 8'h02);
    wr(6'h07, 8'h01);
    @(posedge clk_i);
    chk(tx_irq_o, 1'h0);
    wr(6'h07, 8'h03);
    @(posedge clk_i);
    chk(tx_irq_o, 1'h1);
    wb_sel_i <= 4'hE;
    wr(6'h07, 8'h07);
    wb_sel_i <= 4'hF;
    rc(6'h07, 8'h03);
    wr(6'h08, 8'h07);
    rc(6'h08, 8'h01);
    wr(6'h08, 8'h00);
    rc(6'h08, 8'h01);
    pulse(3'h0, 3'h1);
    chk(abort_grant_o, 3'h1);
    rc(6'h06, 8'h07);
    rc(6'h09, 8'h01);
    rc(6'h08, 8'h00);
    chk(tx_irq_o, 1'h1);
    rc(6'h11, 8'h08);
    wr(6'h09, 8'h00);
    rc(6'h09, 8'h01);
    wr(6'h06, 8'h07);
    rc(6'h09, 8'h00);
    chk(tx_irq_o, 1'h0);
    wr(6'h08, 8'h02);
    pulse(3'h2, 3'h2);
    chk(abort_grant_o, 3'h0);
    rc(6'h06, 8'h02);
    rc(6'h09, 8'h00);
    rc(6'h08, 8'h00);
    rc(6'h11, 8'h0A);
    wr(6'h0A, 8'h04);
    wr(6'h10, 8'h01);
    init_ack_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rc(6'h10, 8'h03);
    chk(init_request_o, 1'h1);
    rc(6'h06, 8'h07);
    rc(6'h07, 8'h00);
    rc(6'h0A, 8'h00);
    wr(6'h07, 8'h05);
    wr(6'h0A, 8'h01);
    rc(6'h07, 8'h00);
    rc(6'h0A, 8'h00);
    rc(6'h08, 8'h00);
    rc(6'h09, 8'h00);
    chk(tx_pending_o, 3'h0);
    init_ack_i <= 1'h0;
    wr(6'h10, 8'h00);
    wr(6'h07, 8'h05);
    rc(6'h07, 8'h05);
    // Abort of a buffer whose frame has not started is granted at once
    tx_busy_i <= 3'h0;
    wr(6'h06, 8'h01);
    wr(6'h08, 8'h01);
    rc(6'h06, 8'h07);
    rc(6'h09, 8'h01);
    // A success while the clock enable is low is lost, the flag stays clear
    wr(6'h06, 8'h02);
    ce_i <= 1'h0;
    pulse(3'h2, 3'h0);
    ce_i <= 1'h1;
    rc(6'h06, 8'h05);
    end_of_test;
  end
endmodule
